// ---- logic/vphy_mgmt_regs.sv ----
// emulated phy management register block with direct and serial access
// How it works
// - pause ability advertised from sym/asym bits of the advertisement register
// - emulated partner mirrors the advertised pause bits
// - manual pause settings apply when negotiation off or manual select set
// - manual pause register reads back duplex and pause now in effect
// - manual pause writes never touch advertisement pause bits
// - chip reset bit resets the phy and self-clears after 102 us
// - control bit 15 resets the phy and self-clears when done
// - every register reachable by direct offset and by serial index
// - serial access answered only when phy address equals the strap
// - serial registers are 16 bits wide
// - indexes 0..6 map to 1c0h..1d8h, index 31 to 1dch
// - negotiated mode is highest common ability, 100 full first
// - no common ability: partner not able, 100 half, one partner bit
// - partner advertises all four speed/duplex abilities when any ability is common
// - negotiation off forces speed and the mode field from control bits; duplex in effect comes from the manual register
module vphy_mgmt_regs #(
  parameter int HOLD_CYC = vphy_pkg::RST_HOLD_CYC, // chip reset bit hold time in cycles
  parameter logic [15:0] ID_HIGH = 16'h0000, // arbitrary identifier value
  parameter logic [15:0] ID_LOW = 16'h0000 // arbitrary identifier value
) (
  input wire logic core_clk_i, // 100 mhz system clock
  input wire logic rst_n_i, // asynchronous chip reset, active low
  input wire logic [4:0] phy_addr_strap_i, // strap phy address, pin
  input wire logic dir_wr_i, // direct write strobe
  input wire logic dir_rd_i, // direct read strobe
  input wire logic [11:0] dir_addr_i, // direct byte offset
  input wire logic [15:0] dir_wdata_i, // direct write data
  output logic [31:0] dir_rdata_o, // direct read data, registered
  input wire logic mii_req_i, // serial access request from host mgmt access register
  input wire logic mii_write_i, // 1 write, 0 read
  input wire logic [4:0] mii_phy_i, // serial phy address
  input wire logic [4:0] mii_index_i, // serial register index
  input wire logic [15:0] mii_wdata_i, // host mgmt data register contents
  output logic [15:0] mii_rdata_o, // serial read data, registered
  output logic mii_done_o, // serial access done pulse
  input wire logic chip_rst_set_i, // software sets the emulated phy reset bit
  output logic emulated_phy_reset_bit_o, // reset bit as seen in chip reset control
  input wire logic manual_wr_i, // write to the manual pause register
  input wire logic [3:0] manual_wdata_i, // {duplex, rx en, tx en, select}
  output logic [6:0] port0_manual_pause_reg_o, // manual settings plus effective ones
  output logic eff_tx_pause_o, // pause transmit in effect
  output logic eff_rx_pause_o, // pause receive in effect
  output logic eff_full_duplex_o, // duplex in effect
  output logic eff_speed100_o // speed in effect
);
  import vphy_pkg::*;

  initial begin
    if (HOLD_CYC < 1) $error("HOLD_CYC must be at least one cycle");
  end

  vphy_neg_if neg ();
  vphy_resolver u_resolver (.neg(neg));

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [4:0] strap_s1_reg, strap_s2_reg, strap_reg;
  logic strap_taken_reg;
  logic [1:0] strap_wait_reg;
  logic an_en_prev_reg;
  logic [15:0] emulated_phy_control_reg, ctrl_next;
  logic [15:0] negotiation_advert_reg, adv_next;
  logic [15:0] special_ctrl_state_reg, spec_next;
  logic [15:0] partner_ability_reg;
  logic lp_able_reg, an_done_reg, page_rx_reg;
  logic [1:0] mode_reg;
  logic [3:0] manual_reg;
  logic [$clog2(HOLD_CYC+1)-1:0] hold_cnt_reg;
  logic chip_rst_reg;
  logic [31:0] dir_rdata_reg;
  logic [15:0] mii_rdata_reg;
  logic mii_done_reg;
  logic [6:0] manual_out_reg;
  logic [3:0] eff_reg;

  // reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // strap synchronised, then caught once; waits until the pin value has crossed both flops
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg <= 5'h00;
      strap_s2_reg <= 5'h00;
      strap_reg <= 5'h00;
      strap_taken_reg <= 1'b0;
      strap_wait_reg <= 2'b00;
    end else begin
      strap_s1_reg <= phy_addr_strap_i;
      strap_s2_reg <= strap_s1_reg;
      strap_wait_reg <= {strap_wait_reg[0], 1'b1};
      if (strap_wait_reg[1] && !strap_taken_reg) begin
        strap_reg <= strap_s2_reg;
        strap_taken_reg <= 1'b1;
      end
    end
  end

  // maps a serial index onto its direct offset; unmapped gives an invalid flag
  function automatic logic [12:0] index_to_offset(input logic [4:0] idx);
    if (idx <= IDX_LAST_BASE) return {1'b1, OFF_CTRL + {5'h00, idx, 2'b00}};
    else if (idx == IDX_SPECIAL) return {1'b1, OFF_SPECIAL};
    else return 13'h0000;
  endfunction : index_to_offset

  // 16-bit register image at a direct offset, zero for anything else
  function automatic logic [15:0] read_reg(input logic [11:0] off, input logic [15:0] ctl,
    input logic [15:0] sts, input logic [15:0] adv, input logic [15:0] lp,
    input logic [15:0] ex, input logic [15:0] sp);
    case (off)
      OFF_CTRL: return ctl;
      OFF_STATE: return sts;
      OFF_ID_HI: return ID_HIGH;
      OFF_ID_LO: return ID_LOW;
      OFF_ADV: return adv;
      OFF_PARTNER: return lp;
      OFF_EXP: return ex;
      OFF_SPECIAL: return sp;
      default: return 16'h0000;
    endcase
  endfunction : read_reg

  // serial access decode: address match and index mapping
  wire addr_hit = mii_req_i && (mii_phy_i == strap_reg);
  wire [12:0] mapped = index_to_offset(mii_index_i);
  wire ser_valid = addr_hit && mapped[12];
  wire ser_wr = ser_valid && mii_write_i;
  // one write port: direct write has priority over a serial write in the same cycle
  wire wr_any = dir_wr_i || ser_wr;
  wire [11:0] wr_off = dir_wr_i ? dir_addr_i : mapped[11:0];
  wire [15:0] wr_data = dir_wr_i ? dir_wdata_i : mii_wdata_i;

  wire [15:0] state_val = STATE_BASE | (16'(an_done_reg) << STATE_AN_DONE);
  wire [15:0] exp_val = (16'(page_rx_reg) << EXP_PAGE_RX) | (16'(lp_able_reg) << EXP_LP_ABLE);
  wire [15:0] spec_val = special_ctrl_state_reg | (16'(mode_reg) << SPEC_MODE_LSB);

  // phy soft reset from either software bit; it restores register defaults
  wire ctrl_rst_req = wr_any && (wr_off == OFF_CTRL) && wr_data[CTRL_RESET];
  wire phy_rst = ctrl_rst_req || chip_rst_reg;
  wire restart_req = wr_any && (wr_off == OFF_CTRL) && wr_data[CTRL_RESTART];
  // negotiation reruns after reset, restart, or when turned on
  wire an_turned_on = emulated_phy_control_reg[CTRL_AN_EN] && !an_en_prev_reg;
  wire renegotiate = phy_rst || restart_req || !an_done_reg || an_turned_on;

  // previous negotiation enable, so a forced mode does not linger once it is back on
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) an_en_prev_reg <= 1'b1;
    else an_en_prev_reg <= emulated_phy_control_reg[CTRL_AN_EN];
  end

  // next register values; reserved and read-only bits keep constants
  always_comb begin
    ctrl_next = emulated_phy_control_reg;
    adv_next = negotiation_advert_reg;
    spec_next = special_ctrl_state_reg;
    if (wr_any && wr_off == OFF_CTRL) ctrl_next = wr_data & CTRL_RW_MASK;
    if (wr_any && wr_off == OFF_ADV) adv_next = (wr_data & ADV_RW_MASK) | ADV_SELECTOR;
    if (wr_any && wr_off == OFF_SPECIAL) spec_next = wr_data & SPECIAL_RW_MASK;
    if (phy_rst) begin
      // reset bit reads 0 once the one-cycle reset is done
      ctrl_next = CTRL_RESET_VAL;
      adv_next = ADV_RESET_VAL;
      spec_next = 16'h0000;
    end
  end

  // register file; manual pause writes reach no advertisement bit
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      emulated_phy_control_reg <= CTRL_RESET_VAL;
      negotiation_advert_reg <= ADV_RESET_VAL;
      special_ctrl_state_reg <= 16'h0000;
    end else begin
      emulated_phy_control_reg <= ctrl_next;
      negotiation_advert_reg <= adv_next;
      special_ctrl_state_reg <= spec_next;
    end
  end

  assign neg.advert = negotiation_advert_reg;
  assign neg.an_en = emulated_phy_control_reg[CTRL_AN_EN];
  assign neg.force_speed = emulated_phy_control_reg[CTRL_SPEED];
  assign neg.force_duplex = emulated_phy_control_reg[CTRL_DUPLEX];

  // negotiation result latched; advert changes reach it only on rerun, while pause in effect reads the live pause bits
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      partner_ability_reg <= 16'h0000;
      lp_able_reg <= 1'b0;
      an_done_reg <= 1'b0;
      page_rx_reg <= 1'b0;
      mode_reg <= 2'b00;
    end else if (renegotiate) begin
      an_done_reg <= !phy_rst;
      page_rx_reg <= !phy_rst;
      partner_ability_reg <= neg.partner;
      lp_able_reg <= neg.lp_able;
      mode_reg <= neg.mode;
    end else if (!neg.an_en) begin
      mode_reg <= neg.mode;
    end
  end

  // chip reset bit: set by software, cleared after the hold count
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chip_rst_reg <= 1'b0;
      hold_cnt_reg <= '0;
    end else if (chip_rst_set_i && !chip_rst_reg) begin
      chip_rst_reg <= 1'b1;
      hold_cnt_reg <= '0;
    end else if (chip_rst_reg) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
      if (hold_cnt_reg == ($bits(hold_cnt_reg))'(HOLD_CYC - 1)) chip_rst_reg <= 1'b0;
    end
  end

  // manual pause register; held settings survive phy resets
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) manual_reg <= 4'h0;
    else if (manual_wr_i) manual_reg <= manual_wdata_i;
  end

  // effective duplex/pause: manual when negotiation off or select set, else resolved
  wire manual_on = !emulated_phy_control_reg[CTRL_AN_EN] || manual_reg[MFC_SELECT];
  wire neg_full = mode_reg[0];
  wire adv_sym = negotiation_advert_reg[ADV_SYM];
  wire adv_asym = negotiation_advert_reg[ADV_ASYM];
  // partner mirrors us, so symmetric pause gives both ways, asym alone gives tx only
  wire an_tx = neg_full && (adv_sym || adv_asym);
  wire an_rx = neg_full && adv_sym;
  wire eff_tx = manual_on ? manual_reg[MFC_TX_EN] : an_tx;
  wire eff_rx = manual_on ? manual_reg[MFC_RX_EN] : an_rx;
  wire eff_dup = manual_on ? manual_reg[MFC_DUPLEX] : neg_full;
  wire [15:0] rd_dir = read_reg(dir_addr_i, emulated_phy_control_reg, state_val,
    negotiation_advert_reg, partner_ability_reg, exp_val, spec_val);
  wire [15:0] rd_ser = read_reg(mapped[11:0], emulated_phy_control_reg, state_val,
    negotiation_advert_reg, partner_ability_reg, exp_val, spec_val);

  // registered answers and effective outputs
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_rdata_reg <= 32'h0000_0000;
      mii_rdata_reg <= 16'h0000;
      mii_done_reg <= 1'b0;
      manual_out_reg <= 7'h00;
      eff_reg <= 4'h0;
    end else begin
      if (dir_rd_i) dir_rdata_reg <= {16'h0000, rd_dir};
      if (addr_hit && !mii_write_i) mii_rdata_reg <= ser_valid ? rd_ser : 16'h0000;
      mii_done_reg <= addr_hit;
      manual_out_reg <= {eff_dup, eff_rx, eff_tx, manual_reg};
      eff_reg <= {mode_reg[1], eff_dup, eff_rx, eff_tx};
    end
  end

  assign dir_rdata_o = dir_rdata_reg;
  assign mii_rdata_o = mii_rdata_reg;
  assign mii_done_o = mii_done_reg;
  assign emulated_phy_reset_bit_o = chip_rst_reg;
  assign port0_manual_pause_reg_o = manual_out_reg;
  assign eff_tx_pause_o = eff_reg[0];
  assign eff_rx_pause_o = eff_reg[1];
  assign eff_full_duplex_o = eff_reg[2];
  assign eff_speed100_o = eff_reg[3];
endmodule : vphy_mgmt_regs

// ---- logic/vphy_pkg.sv ----
// package: register map, field positions, reset values and timing for the emulated phy
package vphy_pkg;
  // direct byte offsets of the eight registers
  localparam logic [11:0] OFF_CTRL = 12'h1c0;
  localparam logic [11:0] OFF_STATE = 12'h1c4;
  localparam logic [11:0] OFF_ID_HI = 12'h1c8;
  localparam logic [11:0] OFF_ID_LO = 12'h1cc;
  localparam logic [11:0] OFF_ADV = 12'h1d0;
  localparam logic [11:0] OFF_PARTNER = 12'h1d4;
  localparam logic [11:0] OFF_EXP = 12'h1d8;
  localparam logic [11:0] OFF_SPECIAL = 12'h1dc;
  // serial register indexes
  localparam logic [4:0] IDX_LAST_BASE = 5'h06;
  localparam logic [4:0] IDX_SPECIAL = 5'h1f;
  // control register fields
  localparam int CTRL_RESET = 15;
  localparam int CTRL_LOOPBACK = 14;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_PWR_DWN = 11;
  localparam int CTRL_ISOLATE = 10;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_COL_TEST = 7;
  localparam logic [15:0] CTRL_RW_MASK = 16'h7d80;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h1000;
  // status register: abilities, an able, an complete, extended; link up bit left clear
  localparam logic [15:0] STATE_BASE = 16'h7809;
  localparam int STATE_AN_DONE = 5;
  // advertisement: ability bits 8:5, pause bits 10 (sym) and 11 (asym), selector 1
  localparam int ADV_HD10 = 5;
  localparam int ADV_FD10 = 6;
  localparam int ADV_HD100 = 7;
  localparam int ADV_FD100 = 8;
  localparam int ADV_SYM = 10;
  localparam int ADV_ASYM = 11;
  localparam logic [15:0] ADV_RW_MASK = 16'h0de0;
  localparam logic [15:0] ADV_RESET_VAL = 16'h01e1;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;
  // expansion fields
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_ABLE = 0;
  // special control/status: rw bits and current mode field
  localparam logic [15:0] SPECIAL_RW_MASK = 16'h00f0;
  localparam int SPEC_MODE_LSB = 2;
  // manual pause register fields (port 0)
  localparam int MFC_SELECT = 0;
  localparam int MFC_TX_EN = 1;
  localparam int MFC_RX_EN = 2;
  localparam int MFC_DUPLEX = 3;
  localparam int MFC_EFF_TX = 4;
  localparam int MFC_EFF_RX = 5;
  localparam int MFC_EFF_DUP = 6;
  // software reset time held by the chip reset bit
  localparam int CLK_MHZ = 100;
  localparam int RST_HOLD_US = 102;
  localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
  // resolved mode codes
  typedef enum logic [1:0] {MODE_HD10, MODE_FD10, MODE_HD100, MODE_FD100} mode_type;
endpackage : vphy_pkg

// ---- logic/vphy_neg_if.sv ----
// interface: advertisement in, negotiation results out, between top and resolver
interface vphy_neg_if;
  logic [15:0] advert;
  logic an_en;
  logic force_speed;
  logic force_duplex;
  logic [15:0] partner;
  logic lp_able;
  logic [1:0] mode;
  modport top (output advert, output an_en, output force_speed, output force_duplex,
    input partner, input lp_able, input mode);
  modport resolver (input advert, input an_en, input force_speed, input force_duplex,
    output partner, output lp_able, output mode);
endinterface : vphy_neg_if

// ---- logic/vphy_resolver.sv ----
// resolver: emulated negotiation outcome and mirrored link partner abilities
module vphy_resolver (
  vphy_neg_if.resolver neg // advertisement in, result out
);
  import vphy_pkg::*;
  wire [3:0] common;
  wire [15:0] pause_mirror;
  wire [15:0] hcd_mode;
  wire no_common;
  assign common = {neg.advert[ADV_FD100], neg.advert[ADV_HD100],
    neg.advert[ADV_FD10], neg.advert[ADV_HD10]};
  assign no_common = (common == 4'h0);
  // partner mirrors the pause bits so the requested pause is accepted on any full-duplex result
  assign pause_mirror = ((16'h0001 << ADV_SYM) & neg.advert) |
    ((16'h0001 << ADV_ASYM) & neg.advert);
  // all four abilities normally; a single 100 half bit on parallel detect
  assign neg.partner = pause_mirror | ADV_SELECTOR | (no_common ? (16'h0001 << ADV_HD100) :
    ((16'h0001 << ADV_FD100) | (16'h0001 << ADV_HD100) |
     (16'h0001 << ADV_FD10) | (16'h0001 << ADV_HD10)));
  assign neg.lp_able = ~no_common;
  // highest common denominator with fixed priority
  assign hcd_mode = common[3] ? 16'(MODE_FD100) : common[2] ? 16'(MODE_HD100) :
    common[1] ? 16'(MODE_FD10) : common[0] ? 16'(MODE_HD10) : 16'(MODE_HD100);
  // forced speed and duplex only when negotiation is off
  assign neg.mode = neg.an_en ? hcd_mode[1:0] :
    {neg.force_speed, neg.force_duplex};
endmodule : vphy_resolver

// ---- test/vphy_mgmt_regs_props.sv ----
// checker: port-level timing relations of the emulated phy register block
module vphy_mgmt_regs_props
  import vphy_pkg::*;
#(parameter int HOLD_CYC = RST_HOLD_CYC) ( // reset bit hold in cycles
  input wire logic core_clk_i, rst_n_i, // clock and reset
  input wire logic [4:0] phy_addr_strap_i, mii_phy_i, // strap and serial address
  input wire logic mii_req_i, mii_done_o, // serial request and done
  input wire logic dir_wr_i, dir_rd_i, // direct strobes
  input wire logic [11:0] dir_addr_i, // direct offset
  input wire logic [15:0] dir_wdata_i, // direct write data
  input wire logic [31:0] dir_rdata_o, // direct read data
  input wire logic chip_rst_set_i, emulated_phy_reset_bit_o, // reset bit
  input wire logic manual_wr_i, eff_tx_pause_o, eff_rx_pause_o, eff_full_duplex_o, // pause
  input wire logic [3:0] manual_wdata_i, // manual write data
  input wire logic [6:0] port0_manual_pause_reg_o // manual readback
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // request for our phy; the strap is static once the block runs
  wire logic hit_w = mii_req_i && (mii_phy_i == phy_addr_strap_i);
  logic [15:0] run_reg;
  // length of the current reset bit pulse, so the hold time is checked exactly
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) run_reg <= 16'h0000;
    else run_reg <= emulated_phy_reset_bit_o ? run_reg + 16'h0001 : 16'h0000;
  end
  sequence s_man_full;
    manual_wr_i && manual_wdata_i[MFC_SELECT] && manual_wdata_i[MFC_DUPLEX] ##1 !manual_wr_i;
  endsequence
  sequence s_ctrl_reset;
    dir_wr_i && dir_addr_i == OFF_CTRL && dir_wdata_i[CTRL_RESET]
      ##2 dir_rd_i && dir_addr_i == OFF_CTRL;
  endsequence
  AST_DONE_HIT: assert property (hit_w |=> mii_done_o)
    else $error("done missing after matching request");
  AST_DONE_MISS: assert property (!hit_w |=> !mii_done_o)
    else $error("done without matching request");
  AST_RST_SET: assert property (chip_rst_set_i && !emulated_phy_reset_bit_o |=> emulated_phy_reset_bit_o)
    else $error("reset bit not set");
  AST_RST_LEN: assert property ($fell(emulated_phy_reset_bit_o) |-> run_reg == HOLD_CYC)
    else $error("reset bit hold time wrong");
  AST_MAN_FULL: assert property (s_man_full |=> eff_full_duplex_o
    && eff_tx_pause_o == $past(manual_wdata_i[MFC_TX_EN], 2)
    && eff_rx_pause_o == $past(manual_wdata_i[MFC_RX_EN], 2)) else $error("manual pause not applied");
  AST_MAN_READ: assert property (manual_wr_i |-> ##2 port0_manual_pause_reg_o[3:0] == $past(manual_wdata_i, 2))
    else $error("manual readback wrong");
  AST_DIR_HIGH: assert property (dir_rd_i |=> dir_rdata_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_DIR_HOLD: assert property (!dir_rd_i |=> $stable(dir_rdata_o))
    else $error("read data changed without read");
  AST_CTRL_SC: assert property (s_ctrl_reset |=> dir_rdata_o == {16'h0000, CTRL_RESET_VAL})
    else $error("control not back at default");
endmodule : vphy_mgmt_regs_props

bind vphy_mgmt_regs vphy_mgmt_regs_props #(.HOLD_CYC(HOLD_CYC)) i_props (.core_clk_i, .rst_n_i,
  .phy_addr_strap_i, .mii_phy_i, .mii_req_i, .mii_done_o, .dir_wr_i, .dir_rd_i, .dir_addr_i,
  .dir_wdata_i, .dir_rdata_o, .chip_rst_set_i, .emulated_phy_reset_bit_o, .manual_wr_i,
  .eff_tx_pause_o, .eff_rx_pause_o, .eff_full_duplex_o, .manual_wdata_i,
  .port0_manual_pause_reg_o);

// ---- test/host_mgmt_model.sv ----
// host mac model: one serial access at a time through access and data registers
module host_mgmt_model (
  input wire logic core_clk_i, // clock
  output logic mii_req_o, mii_write_o, // request pulse, 1 write
  output logic [4:0] mii_phy_o, mii_index_o, // phy address, index
  output logic [15:0] mii_wdata_o, // data register
  input wire logic [15:0] mii_rdata_i, // read data
  input wire logic mii_done_i // done pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle fields other than the request start away from a quiet zero
  initial begin
    mii_req_o = 1'b0;
    mii_write_o = 1'b1;
    mii_phy_o = 5'h15;
    mii_index_o = 5'h0a;
    mii_wdata_o = 16'ha5a5;
  end
  // one-cycle request; phy, index and data fields show inverted values afterwards, write is left as driven
  task automatic access(input logic wr, input logic [4:0] phy, input logic [4:0] idx,
    input logic [15:0] wd, output logic [15:0] rd, output logic dn);
    @(negedge core_clk_i);
    mii_req_o = 1'b1;
    mii_write_o = wr;
    mii_phy_o = phy;
    mii_index_o = idx;
    mii_wdata_o = wd;
    @(negedge core_clk_i);
    dn = mii_done_i;
    rd = mii_rdata_i;
    mii_req_o = 1'b0;
    mii_phy_o = ~phy;
    mii_index_o = ~idx;
    mii_wdata_o = ~wd;
  endtask : access
endmodule : host_mgmt_model

// ---- test/tb.sv ----
// testbench: emulated phy register block against a behavioural register model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vphy_pkg::*;
  localparam int HOLD = 20;
  localparam logic [4:0] STRAP = 5'h0b;
  localparam logic [15:0] ID_H = 16'h2c41; // arbitrary identifier value
  localparam logic [15:0] ID_L = 16'h9e07; // arbitrary identifier value
  logic core_clk_i, rst_n_i, dir_wr_i, dir_rd_i, chip_rst_set_i, manual_wr_i, mii_req, mii_write;
  logic mii_done, rst_bit, eff_tx, eff_rx, eff_dup, eff_sp, dn;
  logic [4:0] mii_phy, mii_index;
  logic [11:0] dir_addr_i;
  logic [15:0] dir_wdata_i, mii_wdata, mii_rdata, q, cw;
  logic [31:0] dir_rdata, dq;
  logic [3:0] manual_wdata_i, mw;
  logic [6:0] man_reg;
  int mdl[32];
  int abl[5] = '{15, 7, 3, 1, 0};
  int idxl[8] = '{0, 1, 2, 3, 4, 5, 6, 31};
  int mode, sp, mismatches, checked, cnt, r, seed = 98;
  host_mgmt_model i_host (.core_clk_i, .mii_req_o(mii_req), .mii_write_o(mii_write),
    .mii_phy_o(mii_phy), .mii_index_o(mii_index), .mii_wdata_o(mii_wdata),
    .mii_rdata_i(mii_rdata), .mii_done_i(mii_done));
  vphy_mgmt_regs #(.HOLD_CYC(HOLD), .ID_HIGH(ID_H), .ID_LOW(ID_L)) i_dut (.core_clk_i,
    .rst_n_i, .phy_addr_strap_i(STRAP), .dir_wr_i, .dir_rd_i, .dir_addr_i, .dir_wdata_i,
    .dir_rdata_o(dir_rdata), .mii_req_i(mii_req), .mii_write_i(mii_write), .mii_phy_i(mii_phy),
    .mii_index_i(mii_index), .mii_wdata_i(mii_wdata), .mii_rdata_o(mii_rdata),
    .mii_done_o(mii_done), .chip_rst_set_i, .emulated_phy_reset_bit_o(rst_bit), .manual_wr_i,
    .manual_wdata_i, .port0_manual_pause_reg_o(man_reg), .eff_tx_pause_o(eff_tx),
    .eff_rx_pause_o(eff_rx), .eff_full_duplex_o(eff_dup), .eff_speed100_o(eff_sp));
  // expected negotiation: partner mirrors pause, best common mode wins
  function automatic void negotiate();
    int a;
    a = (mdl[4] >> 5) & 15;
    mdl[5] = (a != 0 ? 16'h01e0 : 16'h0080) | (mdl[4] & 16'h0c00) | 1;
    mdl[6] = a != 0 ? 3 : 2;
    mode = a[3] ? 3 : a[2] ? 2 : a[1] ? 1 : a[0] ? 0 : 2;
  endfunction : negotiate
  function automatic void mdl_reset();
    mdl = '{default: 0};
    mdl[0] = CTRL_RESET_VAL;
    mdl[1] = STATE_BASE | 16'h0020;
    mdl[2] = ID_H;
    mdl[3] = ID_L;
    mdl[4] = ADV_RESET_VAL;
    negotiate();
  endfunction : mdl_reset
  // unmapped indexes keep nothing, so they read back zero
  function automatic void mdl_write(int i, logic [15:0] d);
    if (i == 0 && d[CTRL_RESET]) mdl_reset();
    else if (i == 0) mdl[0] = d & CTRL_RW_MASK;
    else if (i == 4) mdl[4] = (d & ADV_RW_MASK) | ADV_SELECTOR;
    if (i == 0 && d[CTRL_RESTART] && !d[CTRL_RESET]) negotiate();
  endfunction : mdl_write
  function automatic int rexp(int i);
    return i == 31 ? (mdl[31] | (mode << 2)) : mdl[i];
  endfunction : rexp
  task automatic chk(input logic [31:0] got, input int e, input logic [31:0] m);
    checked++;
    if ((got & m) !== (e[31:0] & m)) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got & m, e[31:0] & m);
    end
  endtask : chk
  // direct bus cycles, inputs moved on the falling edge
  task automatic dwr(input logic [11:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    dir_wr_i = 1'b1;
    dir_addr_i = a;
    dir_wdata_i = d;
    @(negedge core_clk_i);
    dir_wr_i = 1'b0;
    dir_wdata_i = ~d;
  endtask : dwr
  task automatic drd(input logic [11:0] a, output logic [31:0] v);
    @(negedge core_clk_i);
    dir_rd_i = 1'b1;
    dir_addr_i = a;
    @(negedge core_clk_i);
    dir_rd_i = 1'b0;
    v = dir_rdata;
  endtask : drd
  task automatic mwr(input logic [3:0] v);
    @(negedge core_clk_i);
    manual_wr_i = 1'b1;
    manual_wdata_i = v;
    @(negedge core_clk_i);
    manual_wr_i = 1'b0;
    manual_wdata_i = ~v;
  endtask : mwr
  // one register read serially and directly, both against the model
  task automatic srd(input int i, input logic [31:0] m);
    i_host.access(1'b0, STRAP, i[4:0], 16'h0000, q, dn);
    chk({31'h0, dn}, 1, 32'h1);
    chk({16'h0, q}, rexp(i), m);
    drd(OFF_CTRL + 12'(i == 31 ? 28 : 4 * i), dq);
    chk(dq, rexp(i), m);
  endtask : srd
  task automatic swr(input int i, input logic [15:0] d);
    i_host.access(1'b1, STRAP, i[4:0], d, q, dn);
    mdl_write(i, d);
    chk({31'h0, dn}, 1, 32'h1);
  endtask : swr
  task automatic check_all(input int first);
    foreach (idxl[k]) if (k >= first) srd(idxl[k], k == 7 ? 32'h00fc : 32'hffff);
  endtask : check_all
  task automatic end_sim();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // clock and watchdog; the run needs well under 3000 cycles
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    mismatches++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim();
  end
  initial begin
    {rst_n_i, dir_wr_i, dir_rd_i, chip_rst_set_i, manual_wr_i} = 5'h00;
    {dir_addr_i, dir_wdata_i, manual_wdata_i} = 32'h0;
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    mdl_reset();
    check_all(0);
    drd(12'h1e0, dq);
    chk(dq, 0, 32'hffffffff);
    foreach (abl[k]) begin
      r = $random(seed);
      swr(4, {4'h0, r[1:0], 1'b0, abl[k][3:0], 5'h01});
      swr(0, 16'h1200);
      check_all(4);
      repeat (3) @(negedge core_clk_i);
      sp = mode & 1;
      chk({eff_sp, eff_dup, eff_tx, eff_rx}, (mode >> 1) * 8 + sp * 4 + sp * (r[1] | r[0]) * 2 + sp * r[0], 32'hf);
    end
    for (int k = 0; k < 5; k++) begin
      r = $random(seed);
      cw = k < 4 ? {2'b00, k[1], 4'h0, k[0], 8'h00} : CTRL_RESET_VAL;
      mw = {k[0] | k[2], r[1:0], k[2]};
      dwr(OFF_CTRL, cw);
      mdl_write(0, cw);
      mwr(mw);
      repeat (3) @(negedge core_clk_i);
      sp = k < 4 ? k[1] : mode >> 1;
      chk({eff_sp, eff_dup, eff_tx, eff_rx}, sp * 8 + mw[3] * 4 + mw[1] * 2 + mw[2], mw[3] ? 32'hf : 32'hc);
      chk(man_reg, {mw[3], mw[2], mw[1], mw}, {mw[3] ? 3'h7 : 3'h4, 4'hf});
    end
    srd(4, 32'hffff);
    swr(4, 16'h0c41);
    dwr(OFF_CTRL, 16'hc000);
    mdl_write(0, 16'hc000);
    drd(OFF_CTRL, dq);
    chk(dq, mdl[0], 32'hffffffff);
    check_all(0);
    swr(4, 16'h0c41);
    @(negedge core_clk_i);
    chip_rst_set_i = 1'b1;
    @(negedge core_clk_i);
    chip_rst_set_i = 1'b0;
    for (cnt = 0; rst_bit === 1'b1 && cnt < 100; cnt++) @(negedge core_clk_i);
    chk(cnt, HOLD, 32'hffff);
    mdl_reset();
    check_all(0);
    i_host.access(1'b1, STRAP ^ 5'h01, 5'h04, 16'h0c41, q, dn);
    chk({31'h0, dn}, 0, 32'h1);
    srd(4, 32'hffff);
    swr(9, 16'hffff);
    srd(9, 32'hffff);
    end_sim();
  end
endmodule : tb
